// ==== rtl/iabi_top.sv ====
`timescale 1ns/100ps
module iabi_top
  import iabi_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Bus control pins.
  input  wire logic       chip_enable_n,
  input  wire logic       chip_select,
  input  wire logic       read_n,
  input  wire logic       convert_n,
  input  wire logic       byte_half_select,
  input  wire logic       flag_bit_select,
  input  wire logic       run_mode_select,
  // Comparator from the analog section.
  input  wire logic       cmp_positive,
  // Data bus and status.
  output logic [7:0]      bus_data,
  output logic            bus_oe_n,
  output logic            busy,
  output logic            result_ready
);

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] filt;
    logic            wr_prev;
    logic            rd_prev;
    logic [1:0]      div;
    logic [10:0]     cnt;
    iabi_run_type    run;
    logic            pending;
    logic            pol;
    logic            crossed;
    logic [16:0]     acc;
    logic [16:0]     word;
    logic            res_valid;
    iabi_byte_type   byte_idx;
    logic            busy;
    logic [7:0]      bus;
    logic            bus_oe_n;
    logic            buf_ready;
  } iabi_state_type;

  iabi_state_type q_ff;
  iabi_state_type nxt_q;
  logic [NPIN-1:0] pins;
  logic            sel;
  logic            rd_act;
  logic            tick;
  logic            cont;
  logic            wr_fall;
  logic            rd_rise;
  logic            expire;
  logic            push;
  logic            in_ready;
  logic            out_valid;
  logic [16:0]     out_data;
  logic [16:0]     conv_word;

  // High byte with the selected flag on the top line.
  function automatic logic [7:0] hi_byte(input logic [16:0] w, input logic use_ovr);
    hi_byte = {(use_ovr ? w[WORD_OVR] : w[WORD_POL]), w[14:8]};
  endfunction : hi_byte

  // Count to result word; excess over full scale is capped at OVR_MAX.
  function automatic logic [16:0] to_word(input logic [16:0] a, input logic p);
    logic [16:0] ex;
    ex = 17'(a - FULL_SCALE);
    if (a >= FULL_SCALE) to_word = {p, 1'b1, RES_W'((ex > OVR_MAX) ? OVR_MAX : ex)};
    else to_word = {p, 1'b0, a[RES_W-1:0]};
  endfunction : to_word

  assign pins = {cmp_positive, run_mode_select, flag_bit_select, byte_half_select,
                 convert_n, read_n, chip_select, chip_enable_n};
  assign sel       = !q_ff.filt[PIN_CEN] && q_ff.filt[PIN_CS];
  assign rd_act    = sel && !q_ff.filt[PIN_RDN];
  assign tick      = (q_ff.div == DIV_LAST);
  assign cont      = q_ff.filt[PIN_RUN];
  // Only the strobe edge matters; the data pins are never sampled on a write.
  assign wr_fall   = q_ff.wr_prev && !q_ff.filt[PIN_WRN] && sel && !cont;
  assign rd_rise   = !q_ff.rd_prev && q_ff.filt[PIN_RDN] && sel && cont;
  assign expire    = cont && q_ff.cnt == CNT_WINDOW && q_ff.div == DIV_HALF;
  assign push      = tick && q_ff.run == ST_RUN && q_ff.cnt == CNT_LAST;
  assign conv_word = to_word(q_ff.acc, q_ff.pol);

  // A result finishing during a read waits here until the strobe ends.
  iabi_pair_buf #(.WIDTH(WORD_W)) u_buf (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (conv_word),
    .out_valid (out_valid),
    .out_ready (!rd_act),
    .out_data  (out_data)
  );

  always_comb begin
    nxt_q = q_ff;
    // Pins pass three stages; a change counts once stages two and three agree.
    nxt_q.s1      = pins;
    nxt_q.s2      = q_ff.s1;
    nxt_q.s3      = q_ff.s2;
    nxt_q.filt    = (~(q_ff.s2 ^ q_ff.s3) & q_ff.s3) | ((q_ff.s2 ^ q_ff.s3) & q_ff.filt);
    nxt_q.wr_prev = q_ff.filt[PIN_WRN];
    nxt_q.rd_prev = q_ff.filt[PIN_RDN];
    nxt_q.div     = 2'(q_ff.div + 2'h1);

    // Cycle counter; demand mode parks at the end of the post-busy gap.
    if (tick && q_ff.run == ST_RUN) begin
      if (q_ff.cnt == CNT_GAP && !cont && !q_ff.pending) begin
        nxt_q.run = ST_WAIT;
      end else begin
        if (q_ff.cnt == CNT_GAP) nxt_q.pending = 1'b0;
        nxt_q.cnt = (q_ff.cnt == CNT_LAST) ? 11'h000 : 11'(q_ff.cnt + 11'h001);
      end
    end

    // A parked counter resumes as soon as continuous mode is selected.
    if (q_ff.run == ST_WAIT && cont) nxt_q.run = ST_RUN;

    // Strobes: start at once when parked, queue after the lockout otherwise.
    if (wr_fall) begin
      if (q_ff.run == ST_WAIT) begin
        nxt_q.run     = ST_RUN;
        nxt_q.pending = 1'b1;
      end else if (!q_ff.pending && (q_ff.cnt >= CNT_UNLOCK || q_ff.cnt < CNT_GAP)) begin
        nxt_q.pending = 1'b1;
      end
    end

    // Deintegrate counting: zero phase and signal integrate come first.
    if (tick && q_ff.run == ST_RUN) begin
      if (q_ff.cnt == CNT_DEINT) begin
        // The first fast clock always runs, so it counts at once.
        nxt_q.pol     = q_ff.filt[PIN_CMP];
        nxt_q.acc     = FAST_STEP;
        nxt_q.crossed = 1'b0;
      end else if (q_ff.cnt > CNT_DEINT && q_ff.cnt < CNT_SETTLE
                   && (!q_ff.crossed || q_ff.cnt == CNT_SLOW || q_ff.cnt == CNT_OVR)) begin
        // Each subphase re-arms the crossing on its own first clock, which counts too.
        nxt_q.crossed = 1'b0;
        if (q_ff.filt[PIN_CMP] != q_ff.pol) nxt_q.crossed = 1'b1;
        else if (q_ff.cnt < CNT_SLOW) nxt_q.acc = 17'(q_ff.acc + FAST_STEP);
        else if (q_ff.cnt < CNT_OVR || q_ff.acc >= FULL_SCALE) nxt_q.acc = 17'(q_ff.acc + SLOW_STEP);
      end
    end

    // Output latch loads whole words only, and only outside a read.
    if (out_valid && !rd_act) begin
      nxt_q.word      = out_data;
      nxt_q.res_valid = 1'b1;
      nxt_q.byte_idx  = BY_HI_POL;
    end else if (expire) begin
      nxt_q.res_valid = 1'b0;
      nxt_q.byte_idx  = BY_HI_POL;
    end else if (rd_rise) begin
      unique case (q_ff.byte_idx)
        BY_HI_POL: nxt_q.byte_idx = BY_LO;
        BY_LO:     nxt_q.byte_idx = BY_HI_OVR;
        default:   nxt_q.byte_idx = BY_HI_POL;
      endcase
    end

    nxt_q.busy      = nxt_q.cnt >= CNT_BUSY;
    nxt_q.buf_ready = in_ready;
    nxt_q.bus_oe_n  = !rd_act;
    nxt_q.bus       = 8'h00;
    if (cont) begin
      // Byte half and flag selects are not looked at in this mode.
      if (q_ff.res_valid) begin
        unique case (q_ff.byte_idx)
          BY_HI_POL: nxt_q.bus = hi_byte(q_ff.word, 1'b0);
          BY_LO:     nxt_q.bus = q_ff.word[7:0];
          BY_HI_OVR: nxt_q.bus = hi_byte(q_ff.word, 1'b1);
          default:   nxt_q.bus = 8'h00;
        endcase
      end
    end else if (q_ff.filt[PIN_BYT]) begin
      nxt_q.bus = q_ff.word[7:0];
    end else begin
      nxt_q.bus = hi_byte(q_ff.word, q_ff.filt[PIN_FLG]);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_ff          <= '0;
      q_ff.s1       <= 8'h0D;
      q_ff.s2       <= 8'h0D;
      q_ff.s3       <= 8'h0D;
      q_ff.filt     <= 8'h0D;
      q_ff.wr_prev  <= 1'b1;
      q_ff.rd_prev  <= 1'b1;
      q_ff.run      <= ST_RUN;
      q_ff.bus_oe_n <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign bus_data     = q_ff.bus;
  assign bus_oe_n     = q_ff.bus_oe_n;
  assign busy         = q_ff.busy;
  assign result_ready = q_ff.buf_ready;

  // Helper: internal clocks spent with busy high.
  logic [10:0] busy_len_ff;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) busy_len_ff <= 11'h000;
    else if (!q_ff.busy) busy_len_ff <= 11'h000;
    else if (tick) busy_len_ff <= 11'(busy_len_ff + 11'h001);
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_tick_gap;
    !tick [*3] ##1 tick;
  endsequence

  chk_div_four: assert property (tick |=> s_tick_gap)
    else $error("internal tick not every fourth master clock");
  chk_cycle_wrap: assert property (push |=> q_ff.cnt == 11'h000 && !q_ff.busy)
    else $error("cycle did not wrap after 1280 counts");
  chk_busy_width: assert property ($fell(q_ff.busy) |-> busy_len_ff == 11'(BUSY_HIGH))
    else $error("busy high period is not 836 internal clocks");
  chk_busy_rise: assert property ($rose(q_ff.busy) |-> q_ff.cnt == CNT_BUSY)
    else $error("busy rose at the wrong count");
  chk_bus_drive: assert property (rd_act |=> !bus_oe_n)
    else $error("bus not driven during a selected read");
  chk_bus_release: assert property (!rd_act |=> bus_oe_n)
    else $error("bus driven outside a selected read");
  chk_cont_first: assert property (cont && q_ff.res_valid && q_ff.byte_idx == BY_HI_POL
                                   |=> bus_data == hi_byte($past(q_ff.word), 1'b0))
    else $error("first continuous byte is not high byte with polarity");
  chk_expire_clear: assert property (expire && !out_valid |=> !q_ff.res_valid)
    else $error("result survived the read window");
  chk_lock_ignore: assert property (wr_fall && q_ff.run == ST_RUN && !q_ff.pending
                                    && q_ff.cnt >= CNT_GAP && q_ff.cnt < CNT_UNLOCK
                                    |=> !q_ff.pending)
    else $error("strobe accepted during lockout");
  chk_park_gap: assert property (q_ff.run == ST_WAIT
                                 |-> q_ff.cnt == CNT_GAP && !$past(cont) && !busy)
    else $error("demand park away from gap end");
  chk_latch_fall: assert property ($fell(q_ff.busy) |-> $past(push))
    else $error("busy fell without a result being stored");
  chk_demand_low: assert property (!cont && q_ff.filt[PIN_BYT]
                                   |=> bus_data == $past(q_ff.word[7:0]))
    else $error("demand low byte wrong");

endmodule : iabi_top

// ==== inc/iabi_pkg.sv ====
package iabi_pkg;

  // Internal clock is the master clock divided by four.
  localparam int         DIV_RATIO   = 4;
  localparam logic [1:0] DIV_LAST    = 2'(DIV_RATIO - 1);
  localparam logic [1:0] DIV_HALF    = 2'(DIV_RATIO / 2 - 1);

  // Conversion cycle in internal clocks, counted 0 .. CYCLE_LEN-1; busy falls at the wrap.
  localparam int          CYCLE_LEN  = 1280;
  localparam int          ZERO_LEN   = 246;
  localparam int          INTEG_LEN  = 256;
  localparam int          FAST_LEN   = 512;
  localparam int          SLOW_LEN   = 64;
  localparam int          OVR_LEN    = 192;
  localparam int          BUSY_HIGH  = 836;
  localparam int          GAP_LEN    = 125;
  localparam int          LOCK_LEN   = 1100;
  localparam int          WINDOW_LEN = 443;
  localparam logic [10:0] CNT_LAST   = 11'(CYCLE_LEN - 1);
  localparam logic [10:0] CNT_DEINT  = 11'(ZERO_LEN + INTEG_LEN);
  localparam logic [10:0] CNT_SLOW   = 11'(ZERO_LEN + INTEG_LEN + FAST_LEN);
  localparam logic [10:0] CNT_OVR    = 11'(ZERO_LEN + INTEG_LEN + FAST_LEN + SLOW_LEN);
  localparam logic [10:0] CNT_SETTLE = 11'(ZERO_LEN + INTEG_LEN + FAST_LEN + SLOW_LEN + OVR_LEN);
  localparam logic [10:0] CNT_BUSY   = 11'(CYCLE_LEN - BUSY_HIGH);
  localparam logic [10:0] CNT_GAP    = 11'(GAP_LEN);
  localparam logic [10:0] CNT_UNLOCK = 11'(GAP_LEN + LOCK_LEN);
  localparam logic [10:0] CNT_WINDOW = 11'(WINDOW_LEN);

  // Result word: polarity, overrange, 15 magnitude bits.
  localparam int           RES_W      = 15;
  localparam int           WORD_W     = RES_W + 2;
  localparam int           WORD_POL   = RES_W + 1;
  localparam int           WORD_OVR   = RES_W;
  localparam logic [16:0]  FULL_SCALE = 17'h08000;
  localparam logic [16:0]  OVR_MAX    = 17'h000BE;
  localparam logic [16:0]  FAST_STEP  = 17'h00040;
  localparam logic [16:0]  SLOW_STEP  = 17'h00001;

  // Bit positions of the synchronised pin vector.
  localparam int NPIN    = 8;
  localparam int PIN_CEN = 0;
  localparam int PIN_CS  = 1;
  localparam int PIN_RDN = 2;
  localparam int PIN_WRN = 3;
  localparam int PIN_BYT = 4;
  localparam int PIN_FLG = 5;
  localparam int PIN_RUN = 6;
  localparam int PIN_CMP = 7;

  typedef enum logic {ST_WAIT, ST_RUN} iabi_run_type;
  typedef enum logic [1:0] {BY_HI_POL, BY_LO, BY_HI_OVR} iabi_byte_type;

endpackage : iabi_pkg

// ==== rtl/iabi_pair_buf.sv ====
`timescale 1ns/100ps
module iabi_pair_buf #(
  parameter int WIDTH = 17
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0]       fill;
  } iabi_buf_type;

  iabi_buf_type q_ff;
  iabi_buf_type nxt_q;
  logic         push;
  logic         pop;

  assign in_ready  = (q_ff.fill != 2'h2);
  assign out_valid = (q_ff.fill != 2'h0);
  assign out_data  = q_ff.head;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_q = q_ff;
    unique case ({push, pop})
      2'b10: begin
        if (q_ff.fill == 2'h0) nxt_q.head = in_data;
        else nxt_q.tail = in_data;
        nxt_q.fill = 2'(q_ff.fill + 2'h1);
      end
      2'b01: begin
        nxt_q.head = q_ff.tail;
        nxt_q.fill = 2'(q_ff.fill - 2'h1);
      end
      2'b11: begin
        // One word leaves while another arrives; the count stays.
        if (q_ff.fill == 2'h1) nxt_q.head = in_data;
        else begin
          nxt_q.head = q_ff.tail;
          nxt_q.tail = in_data;
        end
      end
      2'b00: nxt_q = q_ff;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) q_ff <= '0;
    else q_ff <= nxt_q;
  end

endmodule : iabi_pair_buf

// ==== sim/iabi_host_model.sv ====
`timescale 1ns/100ps
module iabi_host_model (
  // Clock.
  input  wire logic       mclk,
  // Pins towards the converter.
  output logic            chip_enable_n,
  output logic            chip_select,
  output logic            read_n,
  output logic            convert_n,
  output logic            byte_half_select,
  output logic            flag_bit_select,
  // Bus as the host sees it.
  input  wire logic [7:0] bus_data,
  input  wire logic       bus_oe_n,
  output logic [7:0]      bus_seen
);
  logic [7:0] last_ff = 8'h00;
  // No pull resistor, so a released bus shows the inverse of its last value, never a stale copy.
  always @(posedge mclk) begin
    if (!bus_oe_n) last_ff <= bus_data;
  end
  assign bus_seen = bus_oe_n ? ~last_ff : bus_data;
  initial begin
    chip_enable_n    = 1'b1;
    chip_select      = 1'b0;
    read_n           = 1'b1;
    convert_n        = 1'b1;
    byte_half_select = 1'b0;
    flag_bit_select  = 1'b0;
  end
  task automatic sel(input logic ce_n, input logic cs);
    @(posedge mclk);
    chip_enable_n <= ce_n;
    chip_select   <= cs;
  endtask : sel
  // The bus is left alone during a strobe, since nothing is written.
  task automatic cnv(input logic lvl);
    @(posedge mclk);
    convert_n <= lvl;
  endtask : cnv
  task automatic rd(input logic bh, input logic fs);
    int n;
    @(posedge mclk);
    byte_half_select <= bh;
    flag_bit_select  <= fs;
    repeat (2) @(posedge mclk);
    read_n <= 1'b0;
    n = 0;
    while (bus_oe_n !== 1'b0 && n < 12) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    read_n <= 1'b1;
    n = 0;
    while (bus_oe_n !== 1'b1 && n < 12) begin
      @(posedge mclk);
      n++;
    end
    repeat (4) @(posedge mclk);
  endtask : rd
endmodule : iabi_host_model

// ==== sim/iabi_top_tb.sv ====
`timescale 1ns/100ps
module iabi_top_tb
  import iabi_pkg::*;
;
  logic       mclk, resetn, run_mode_select, cmp_positive;
  logic       chip_enable_n, chip_select, read_n, convert_n;
  logic       byte_half_select, flag_bit_select, bus_oe_n, busy, result_ready;
  logic [7:0] bus_data, bus_seen;
  logic       prev_oe_n, pa, r1, r2, bh;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [31:0] seed;
  int         n_fail, checks, n1, n2, n3;
  int         jc, m;
  logic [14:0] v;

  iabi_top DUT (.mclk(mclk), .resetn(resetn), .chip_enable_n(chip_enable_n),
    .chip_select(chip_select), .read_n(read_n), .convert_n(convert_n),
    .byte_half_select(byte_half_select), .flag_bit_select(flag_bit_select),
    .run_mode_select(run_mode_select), .cmp_positive(cmp_positive), .bus_data(bus_data),
    .bus_oe_n(bus_oe_n), .busy(busy), .result_ready(result_ready));
  iabi_host_model host (.mclk(mclk), .chip_enable_n(chip_enable_n), .chip_select(chip_select),
    .read_n(read_n), .convert_n(convert_n), .byte_half_select(byte_half_select),
    .flag_bit_select(flag_bit_select), .bus_data(bus_data), .bus_oe_n(bus_oe_n),
    .bus_seen(bus_seen));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic roll(output logic b);
    seed = seed[0] ? ((seed >> 1) ^ 32'hA3000000) : (seed >> 1);
    b = seed[3];
  endtask : roll

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input logic le);
    checks++;
    if ($isunknown(got) || (le ? (got > exp) : (got !== exp))) begin
      n_fail++;
      $display("mismatch at %0t: byte %h against %h (bound %b)", $time, got, exp, le);
    end
  endtask : cmp_byte

  task automatic cmp_num(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
    end
  endtask : cmp_num

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_busy

  task automatic stop_test;
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Every first cycle of a driven bus is one read result; the oldest note is its expectation.
  always @(posedge mclk) begin
    prev_oe_n <= bus_oe_n;
    if (resetn === 1'b1 && bus_oe_n === 1'b0 && prev_oe_n === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("mismatch at %0t: bus driven with no read expected", $time);
      end else begin
        e = exp_q.pop_front();
        cmp_byte(bus_seen, e[7:0], e[8]);
      end
    end
  end

  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    resetn          = 1'b0;
    run_mode_select = 1'b0;
    cmp_positive    = 1'b0;
    seed            = 32'd67245;
    repeat (6) @(posedge mclk);
    cmp_byte({5'h00, result_ready, bus_oe_n, busy}, 8'h02, 1'b0);
    resetn <= 1'b1;
    repeat (600) @(posedge mclk);
    cmp_byte({7'h00, result_ready}, 8'h01, 1'b0);
    // Strobes with only one of the two selects active.
    for (int i = 0; i < 2; i++) begin
      host.sel(1'(i), 1'(i));
      host.cnv(1'b0);
      repeat (8) @(posedge mclk);
      host.cnv(1'b1);
      repeat (8) @(posedge mclk);
    end
    wait_busy(1'b1, 2000, n1);
    cmp_num(n1, 2000, 2000);
    host.sel(1'b0, 1'b1);
    // Demand conversion with the strobe held low, released and struck again too early.
    roll(pa);
    cmp_positive <= pa;
    host.cnv(1'b0);
    fork
      begin
        wait_busy(1'b1, 2000, n1);
        wait_busy(1'b0, 4000, n2);
      end
      begin
        repeat (1200) @(posedge mclk);
        host.cnv(1'b1);
        repeat (400) @(posedge mclk);
        host.cnv(1'b0);
      end
    join
    cmp_num(n1 + n2, (CYCLE_LEN - GAP_LEN) * DIV_RATIO, (CYCLE_LEN - GAP_LEN) * DIV_RATIO + 20);
    cmp_num(n2, BUSY_HIGH * DIV_RATIO, BUSY_HIGH * DIV_RATIO);
    wait_busy(1'b1, 2400, n3);
    cmp_num(n3, 2400, 2400);
    for (int i = 0; i < 5; i++) begin
      bh = (i == 2 || i == 3);
      exp_q.push_back(bh ? {1'b1, OVR_MAX[7:0]} : (i[0] ? 9'h080 : {1'b0, pa, 7'h00}));
      host.rd(bh, i[0]);
    end
    host.sel(1'b1, 1'b1);
    host.rd(1'b0, 1'b1);
    host.sel(1'b0, 1'b0);
    host.rd(1'b1, 1'b0);
    host.sel(1'b0, 1'b1);
    // Late strobe during a conversion queues the next one with no parking.
    cmp_positive <= ~pa;
    host.cnv(1'b1);
    repeat (8) @(posedge mclk);
    host.cnv(1'b0);
    fork
      begin
        wait_busy(1'b1, 2000, n1);
        wait_busy(1'b0, 4000, n2);
        wait_busy(1'b1, 3000, n3);
      end
      begin
        repeat (2000) @(posedge mclk);
        host.cnv(1'b1);
        repeat (2500) @(posedge mclk);
        host.cnv(1'b0);
      end
    join
    cmp_num(n3, (CYCLE_LEN - BUSY_HIGH) * DIV_RATIO, (CYCLE_LEN - BUSY_HIGH) * DIV_RATIO);
    exp_q.push_back({1'b0, ~pa, 7'h00});
    host.rd(1'b0, 1'b0);
    wait_busy(1'b0, 4000, n2);
    cmp_num(n2, BUSY_HIGH * DIV_RATIO - 40, BUSY_HIGH * DIV_RATIO);
    host.cnv(1'b1);
    // Comparator turns in the fast and the slow phase give an in-range count.
    repeat (8) @(posedge mclk);
    roll(pa);
    jc = 100 + int'(seed[8:0]) % 400;
    m  = 1 + int'(seed[14:9]) % 63;
    v  = 15'(64 * jc + m);
    cmp_positive <= pa;
    host.cnv(1'b0);
    wait_busy(1'b1, 3000, n1);
    // Each turn lands two master clocks before the internal tick that must see it.
    repeat (228 + 4 * jc) @(posedge mclk);
    cmp_positive <= ~pa;
    repeat (2048 - 4 * jc) @(posedge mclk);
    cmp_positive <= pa;
    repeat (4 * m) @(posedge mclk);
    cmp_positive <= ~pa;
    wait_busy(1'b0, 4000, n2);
    for (int i = 0; i < 4; i++) begin
      roll(r1);
      roll(r2);
      exp_q.push_back({1'b0, (r1 ? v[7:0] : {(r2 ? 1'b0 : pa), v[14:8]})});
      host.rd(r1, r2);
    end
    // Parked again before the mode changes, so continuous mode must leave the park.
    repeat (1000) @(posedge mclk);
    // Continuous mode: three cycles, full sequence, partial read with expiry, then restart.
    roll(pa);
    cmp_positive    <= pa;
    run_mode_select <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wait_busy(1'b1, 6000, n1);
      wait_busy(1'b0, 4000, n1);
    end
    wait_busy(1'b1, 2000, n1);
    wait_busy(1'b0, 4000, n2);
    cmp_num(n1 + n2, CYCLE_LEN * DIV_RATIO, CYCLE_LEN * DIV_RATIO);
    for (int c = 0; c < 3; c++) begin
      for (int b = 0; b < ((c == 1) ? 1 : 3); b++) begin
        roll(r1);
        roll(r2);
        exp_q.push_back(b == 0 ? {1'b0, pa, 7'h00} : (b == 1 ? {1'b1, OVR_MAX[7:0]} : 9'h080));
        host.rd(r1, r2);
      end
      if (c == 2) begin
        repeat (1800) @(posedge mclk);
        exp_q.push_back(9'h000);
        host.rd(1'b0, 1'b0);
      end
      wait_busy(1'b1, 6000, n1);
      wait_busy(1'b0, 4000, n1);
    end
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("mismatch at %0t: %0d reads never answered", $time, exp_q.size());
    end
    stop_test();
  end
endmodule : iabi_top_tb
